/* hw/fifo_stack_pkg.sv */
/*
 Shared constants and carrier types for the word FIFO stack.
 Assumes a single core_clk domain and a controller issuing one-cycle triggers.
*/
package fifo_stack_pkg;
    localparam int WORD_W = 16;
    localparam int MAX_LEN = 512;
    localparam int MIN_LEN = 2;
    localparam int LEN_W = 10;
    localparam logic [WORD_W-1:0] PTR_RESET = 16'h0000;
    localparam logic [WORD_W-1:0] WORD_ZERO = 16'h0000;
    localparam logic [WORD_W-1:0] PTR_STEP = 16'h0001;

    typedef struct packed {
        logic push;
        logic pop;
        logic clear;
        logic [WORD_W-1:0] src;
        logic [LEN_W-1:0] len;
    } fifo_cmd_s;

    typedef struct packed {
        logic done;
        logic carry;
        logic [WORD_W-1:0] dst;
        logic [WORD_W-1:0] ptr;
    } fifo_rsp_s;
endpackage

/* hw/word_fifo_stack.sv */
/*
 Word FIFO stack: a run of len words; word 0 is the fill-count pointer,
 entries sit at 1..ptr. Push and pop each complete in one cycle.
 Assumes cmd comes from logic on core_clk, one-cycle pulses, len in 2..512.
 A len above DEPTH is held to DEPTH words, so a small DEPTH stays safe.
*/
// Contract
// [RULE_01] Run of n words from head is a FIFO stack; word zero is pointer.
// [RULE_02] Push first increments the pointer by one.
// [RULE_03] Push then stores source word at head plus new pointer.
// [RULE_04] Push past n-1 stops without storing and sets carry flag.
// [RULE_05] Controller issues push and pop as single pulses per event.
// [RULE_06] Controller keeps stack length n within 2 to 512, pointer included.
// [RULE_07] Pointer always equals number of entries held.
// [RULE_08] Pop outputs oldest entry, at head plus one, to destination.
// [RULE_09] Pop shifts remaining entries toward head, then decrements pointer.
// [RULE_10] Pop with pointer zero stops without moving data, sets carry flag.
// [RULE_11] Controller clears the pointer before the first push.
// [RULE_12] Each trigger performs exactly one push into the next location.
// [RULE_13] Sixteen-bit words; pop shift completes within one operation.
module word_fifo_stack
    import fifo_stack_pkg::*;
#(
    parameter int DEPTH = MAX_LEN
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire fifo_stack_pkg::fifo_cmd_s cmd,
    output fifo_stack_pkg::fifo_rsp_s rsp
);
    import fifo_stack_pkg::*;

    typedef struct packed {
        logic [DEPTH-1:1][WORD_W-1:0] mem;
        logic [WORD_W-1:0] ptr;
        logic [WORD_W-1:0] dst;
        logic carry;
        logic done;
    } state_s;

    // Index width covers slots 1..DEPTH-1
    localparam int IDX_W = $clog2(DEPTH);
    localparam logic [WORD_W-1:0] DEPTH_WORDS = WORD_W'(DEPTH);

    state_s st_r;
    state_s st_nxt;
    logic [WORD_W-1:0] len_words;
    logic [WORD_W-1:0] eff_len;
    logic [WORD_W-1:0] limit;
    logic [WORD_W-1:0] ptr_inc;
    logic [DEPTH-1:1][WORD_W-1:0] shifted;

    // Length beyond the storage is held to DEPTH, so no write leaves the array
    assign len_words = WORD_W'(cmd.len);
    assign eff_len = (len_words > DEPTH_WORDS) ? DEPTH_WORDS : len_words;
    assign limit = eff_len - PTR_STEP;
    assign ptr_inc = st_r.ptr + PTR_STEP;

    // Every entry moves one slot toward the head in a single cycle
    genvar gi;
    generate
        for (gi = 1; gi < DEPTH; gi++) begin : g_shift
            if (gi == DEPTH - 1) begin : g_last
                assign shifted[gi] = WORD_ZERO;
            end else begin : g_mid
                assign shifted[gi] = st_r.mem[gi+1]; // [RULE_09] [RULE_13]
            end
        end
    endgenerate

    always_comb begin
        st_nxt = st_r;
        st_nxt.done = 1'b0;
        if (cmd.clear) begin
            st_nxt.ptr = PTR_RESET;
        end else if (cmd.push) begin
            st_nxt.done = 1'b1;
            if (ptr_inc > limit) begin
                st_nxt.carry = 1'b1; // [RULE_04]
            end else begin
                st_nxt.carry = 1'b0;
                st_nxt.ptr = ptr_inc; // [RULE_02] [RULE_07] [RULE_12]
                st_nxt.mem[ptr_inc[IDX_W-1:0]] = cmd.src; // [RULE_03] [RULE_01]
            end
        end else if (cmd.pop) begin
            st_nxt.done = 1'b1;
            if (st_r.ptr == WORD_ZERO) begin
                st_nxt.carry = 1'b1; // [RULE_10]
            end else begin
                st_nxt.carry = 1'b0;
                st_nxt.dst = st_r.mem[1]; // [RULE_08]
                st_nxt.mem = shifted; // [RULE_09]
                st_nxt.ptr = st_r.ptr - PTR_STEP; // [RULE_07]
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rsp = '{done: st_r.done, carry: st_r.carry, dst: st_r.dst, ptr: st_r.ptr};

    // Checker view of the rules, formed from cmd.len apart from the datapath
    logic len_ok;
    logic [WORD_W-1:0] chk_top;
    logic chk_full;
    logic push_go;
    logic pop_go;

    assign len_ok = (cmd.len >= LEN_W'(MIN_LEN)) && (len_words <= DEPTH_WORDS);
    assign chk_top = len_words - PTR_STEP;
    assign chk_full = st_r.ptr >= chk_top;
    assign push_go = cmd.push && !cmd.clear;
    assign pop_go = cmd.pop && !cmd.push && !cmd.clear;

    // Each rule but the ptr_range_a bound is checked one cycle after its trigger is taken
    push_full_a: assert property ( // [RULE_04]
        @(posedge core_clk) disable iff (rst)
        len_ok && push_go && chk_full
        |=> rsp.carry && rsp.done && $stable(rsp.ptr)
    ) else $error("push on full stack did not flag carry");

    push_refuse_a: assert property ( // [RULE_04]
        @(posedge core_clk) disable iff (rst)
        len_ok && push_go && chk_full
        |=> st_r.mem == $past(st_r.mem)
    ) else $error("refused push changed stored entries");

    push_store_a: assert property ( // [RULE_03]
        @(posedge core_clk) disable iff (rst)
        len_ok && push_go && !chk_full
        |=> st_r.mem[rsp.ptr[IDX_W-1:0]] == $past(cmd.src)
    ) else $error("push did not store word at new pointer");

    push_step_a: assert property ( // [RULE_02]
        @(posedge core_clk) disable iff (rst)
        len_ok && push_go && !chk_full
        |=> rsp.ptr == $past(rsp.ptr) + PTR_STEP && !rsp.carry && rsp.done
    ) else $error("push did not advance pointer by one");

    push_keep_a: assert property ( // [RULE_12]
        @(posedge core_clk) disable iff (rst)
        len_ok && push_go && !chk_full && rsp.ptr != WORD_ZERO
        |=> st_r.mem[1] == $past(st_r.mem[1])
    ) else $error("push disturbed the oldest entry");

    head_entry_a: assert property ( // [RULE_01]
        @(posedge core_clk) disable iff (rst)
        len_ok && push_go && !chk_full && rsp.ptr == WORD_ZERO
        |=> st_r.mem[1] == $past(cmd.src)
    ) else $error("first entry not placed right after pointer");

    dst_hold_a: assert property ( // [RULE_08]
        @(posedge core_clk) disable iff (rst)
        push_go
        |=> $stable(rsp.dst)
    ) else $error("push changed the destination word");

    pop_empty_a: assert property ( // [RULE_10]
        @(posedge core_clk) disable iff (rst)
        pop_go && rsp.ptr == WORD_ZERO
        |=> rsp.carry && rsp.done && rsp.ptr == WORD_ZERO && $stable(rsp.dst)
    ) else $error("pop on empty stack did not flag carry");

    pop_refuse_a: assert property ( // [RULE_10]
        @(posedge core_clk) disable iff (rst)
        pop_go && rsp.ptr == WORD_ZERO
        |=> st_r.mem == $past(st_r.mem)
    ) else $error("refused pop moved stored entries");

    pop_read_a: assert property ( // [RULE_08]
        @(posedge core_clk) disable iff (rst)
        pop_go && rsp.ptr != WORD_ZERO
        |=> rsp.dst == $past(st_r.mem[1]) && rsp.ptr == $past(rsp.ptr) - PTR_STEP && !rsp.carry
    ) else $error("pop returned wrong word or pointer");

    pop_shift_a: assert property ( // [RULE_09]
        @(posedge core_clk) disable iff (rst)
        pop_go && rsp.ptr > PTR_STEP
        |=> st_r.mem[1] == $past(st_r.mem[2])
    ) else $error("pop did not shift entries toward head");

    done_pulse_a: assert property ( // [RULE_12]
        @(posedge core_clk) disable iff (rst)
        !cmd.push && !cmd.pop
        |=> !rsp.done
    ) else $error("done without a trigger");

    op_done_a: assert property ( // [RULE_13]
        @(posedge core_clk) disable iff (rst)
        (cmd.push || cmd.pop) && !cmd.clear
        |=> rsp.done
    ) else $error("operation did not complete in one cycle");

    idle_hold_a: assert property ( // [RULE_07]
        @(posedge core_clk) disable iff (rst)
        !cmd.push && !cmd.pop && !cmd.clear
        |=> $stable(rsp.ptr) && $stable(rsp.dst) && $stable(rsp.carry)
    ) else $error("state changed without a trigger");

    clear_ptr_a: assert property ( // [RULE_07]
        @(posedge core_clk) disable iff (rst)
        cmd.clear
        |=> rsp.ptr == PTR_RESET && !rsp.done
    ) else $error("clear did not zero pointer");

    ptr_range_a: assert property ( // [RULE_07]
        @(posedge core_clk) disable iff (rst)
        rsp.ptr < DEPTH_WORDS
    ) else $error("pointer left the storage range");

    // Main scenarios
    push_ok_c: cover property (@(posedge core_clk) disable iff (rst)
        push_go ##1 push_go ##1 rsp.ptr == PTR_STEP + PTR_STEP);
    full_c: cover property (@(posedge core_clk) disable iff (rst)
        push_go && chk_full ##1 rsp.carry);
    pop_ok_c: cover property (@(posedge core_clk) disable iff (rst)
        pop_go ##1 (rsp.done && !rsp.carry));
    empty_c: cover property (@(posedge core_clk) disable iff (rst)
        pop_go ##1 rsp.carry);
    clear_c: cover property (@(posedge core_clk) disable iff (rst)
        cmd.clear && cmd.push ##1 rsp.ptr == PTR_RESET);
endmodule

/* tb/fifo_ctrl_model.sv */
/*
 Controller model: issues one-cycle push, pop and clear triggers.
 Assumes core_clk from the bench; cmd changes 1 ns after a rising edge.
*/
module fifo_ctrl_model
    import fifo_stack_pkg::*;
(
    input wire logic core_clk,
    output fifo_stack_pkg::fifo_cmd_s cmd
);
    timeunit 1ns;
    timeprecision 100ps;
    initial cmd = '{1'b0, 1'b0, 1'b0, 16'h0000, 10'h004};
    // Kind bits are clear, push, pop
    task automatic op(input logic [2:0] kind, input logic [15:0] word);
        @(posedge core_clk);
        #1;
        {cmd.clear, cmd.push, cmd.pop} = kind;
        cmd.src = word;
        @(posedge core_clk);
        #1;
        {cmd.clear, cmd.push, cmd.pop} = 3'h0;
        cmd.src = ~word;
    endtask
endmodule

/* tb/testbench.sv */
/*
 Table-driven bench for the word FIFO stack with a length of four words.
 Assumes fifo_ctrl_model drives cmd and the design answers one cycle later.
*/
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    import fifo_stack_pkg::*;
    typedef struct packed {
        logic [2:0] kind;
        logic [15:0] src;
        fifo_rsp_s rsp;
    } row_s;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    fifo_cmd_s cmd;
    fifo_rsp_s rsp;
    int error_cnt = 0;
    int n_checks = 0;
    row_s rows [9] = '{
        '{3'h4, 16'h0000, '{1'b0, 1'b0, 16'h0000, 16'h0000}}, '{3'h2, 16'h1111, '{1'b1, 1'b0, 16'h0000, 16'h0001}},
        '{3'h2, 16'h2222, '{1'b1, 1'b0, 16'h0000, 16'h0002}}, '{3'h2, 16'h3333, '{1'b1, 1'b0, 16'h0000, 16'h0003}},
        '{3'h2, 16'h4444, '{1'b1, 1'b1, 16'h0000, 16'h0003}}, '{3'h1, 16'h0000, '{1'b1, 1'b0, 16'h1111, 16'h0002}},
        '{3'h1, 16'h0000, '{1'b1, 1'b0, 16'h2222, 16'h0001}}, '{3'h1, 16'h0000, '{1'b1, 1'b0, 16'h3333, 16'h0000}},
        '{3'h1, 16'h0000, '{1'b1, 1'b1, 16'h3333, 16'h0000}}};
    always #4 core_clk = ~core_clk;
    fifo_ctrl_model u_fifo_ctrl_model (.core_clk(core_clk), .cmd(cmd));
    word_fifo_stack #(.DEPTH(8)) u_word_fifo_stack (.core_clk(core_clk), .rst(rst), .cmd(cmd), .rsp(rsp));
    task automatic check(input logic ok, input string what);
        n_checks++;
        if (ok !== 1'b1) begin
            error_cnt++;
            $display("Error at %0t: %s", $time, what);
        end
    endtask
    task automatic give_verdict();
        $display("Checks %0d, errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge core_clk);
        #1 rst = 1'b0;
        foreach (rows[i]) begin
            u_fifo_ctrl_model.op(rows[i].kind, rows[i].src);
            check(rsp === rows[i].rsp, "table row mismatch");
            @(posedge core_clk);
            #1 check(rsp.done === 1'b0, "done longer than one cycle");
        end
        $display("Table test done");
        u_fifo_ctrl_model.op(3'h2, 16'hABCD);
        rst = 1'b1;
        #1 check(rsp === '0, "outputs not cleared by reset");
        @(posedge core_clk);
        #1 rst = 1'b0;
        u_fifo_ctrl_model.op(3'h2, 16'h5A5A);
        u_fifo_ctrl_model.op(3'h1, 16'h0000);
        check(rsp.dst === 16'h5A5A && rsp.ptr === 16'h0000, "pop after reset");
        $display("Reset test done");
        u_fifo_ctrl_model.op(3'h2, 16'h0F0F);
        u_fifo_ctrl_model.op(3'h6, 16'hF0F0);
        check(rsp.done === 1'b0 && rsp.ptr === 16'h0000, "clear did not override push");
        u_fifo_ctrl_model.op(3'h3, 16'h7E7E);
        check(rsp === fifo_rsp_s'{1'b1, 1'b0, 16'h5A5A, 16'h0001}, "push did not override pop");
        u_fifo_ctrl_model.op(3'h1, 16'h0000);
        check(rsp === fifo_rsp_s'{1'b1, 1'b0, 16'h7E7E, 16'h0000}, "pop missed new entry");
        $display("Priority test done");
        give_verdict();
    end
    initial begin
        #3000;
        error_cnt++;
        $display("Error at %0t: watchdog expired", $time);
        give_verdict();
    end
endmodule
